// *** wdt_watchdog_unit.sv ***
// Function
// - When the counter overflows the block asserts a whole-system reset request.
// - After any reset the watchdog is enabled and counting at its longest interval.
// - Software can disable the watchdog as long as it is not locked.
// - Once locked, disable attempts are ignored until the next system reset.
// - While locked, configuration changes including the interval are rejected.
// - A watchdog reset never drives or changes the external reset pin.
// - The counter advances only on the slow oscillator, not the system clock.
// - The slow oscillator runs at a nominal 80 kHz, setting the timeout granularity.
`timescale 1ns/1ps
`include "wdt_map.svh"

module wdt_watchdog_unit
    import wdt_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // software control strobes
    input wire logic restart,
    input wire logic enable_we,
    input wire logic enable_val,
    input wire logic lock_req,
    input wire logic interval_we,
    input wire logic [`WDT_SEL_W-1:0] interval_val,
    // status
    output logic wdt_enabled,
    output logic wdt_locked,
    output logic [`WDT_SEL_W-1:0] wdt_interval,
    output logic [`WDT_CNT_W-1:0] wdt_count,
    output logic write_refused,
    output logic osc_tick,
    // system reset request
    output logic sys_reset_req,
    // external reset pin, never driven
    output logic rst_pin_out,
    output logic rst_pin_oe_n
);
    localparam logic [`WDT_FIRE_W-1:0] FIRE_LAST = `WDT_FIRE_W'(`WDT_FIRE_CYCLES - 1);

    wdt_state_e state;
    wdt_state_e next_state;
    logic restart_pend;
    logic [`WDT_FIRE_W-1:0] fire_cnt;
    logic [`WDT_CNT_W-1:0] limit;
    logic overflow;
    logic disable_try;
    logic cfg_try;
    logic interval_ok;
    logic disable_ok;
    logic fire_done;

    function automatic logic [`WDT_CNT_W-1:0] wdt_limit(input logic [`WDT_SEL_W-1:0] sel);
        logic [4:0] sh;
        sh = {1'b0, sel, 1'b0} + `WDT_SEL_SHIFT_BASE;
        // sel 7 is the longest interval, 2^18 ticks
        return (`WDT_CNT_W'h1 << sh) - `WDT_CNT_W'h1;
    endfunction : wdt_limit

    // a control write lands only while unlocked
    function automatic logic wdt_accept(input logic we, input logic locked);
        return we && !locked;
    endfunction : wdt_accept

    // slow oscillator tick, 80 kHz from the system clock
    wdt_slow_osc_div u_osc (
        .clk(clk),
        .resetn(resetn),
        .osc_tick(osc_tick)
    );

    assign limit = wdt_limit(wdt_interval);
    assign overflow = osc_tick && !restart_pend && (wdt_count >= limit);
    assign disable_try = enable_we && !enable_val;
    assign cfg_try = enable_we || interval_we;
    assign interval_ok = wdt_accept(interval_we, wdt_locked);
    assign disable_ok = wdt_accept(disable_try, wdt_locked) && !lock_req;
    assign fire_done = (fire_cnt == FIRE_LAST);

    // the watchdog reset is internal only
    assign rst_pin_out = 1'b0;
    assign rst_pin_oe_n = 1'b1;

    // lock is sticky until system reset
    always_ff @(posedge clk) begin
        if (!resetn) begin
            wdt_locked <= 1'b0;
        end else if (lock_req) begin
            wdt_locked <= 1'b1;
        end
    end

    // configuration, frozen while locked
    always_ff @(posedge clk) begin
        if (!resetn) begin
            wdt_interval <= `WDT_SEL_RESET;
        end else if (interval_ok) begin
            wdt_interval <= interval_val;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            write_refused <= 1'b0;
        end else begin
            write_refused <= cfg_try && wdt_locked;
        end
    end

    // restart waits for the next slow tick; a new restart wins over consumption
    always_ff @(posedge clk) begin
        if (!resetn) begin
            restart_pend <= 1'b0;
        end else if (restart || interval_ok) begin
            restart_pend <= 1'b1;
        end else if (osc_tick) begin
            restart_pend <= 1'b0;
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            WDT_ST_OFF: begin
                if ((enable_we && enable_val) || lock_req) begin
                    next_state = WDT_ST_RUN;
                end
            end
            WDT_ST_RUN: begin
                if (disable_ok) begin
                    next_state = WDT_ST_OFF;
                end else if (overflow) begin
                    next_state = WDT_ST_FIRE;
                end
            end
            WDT_ST_FIRE: begin
                if (fire_done) begin
                    next_state = WDT_ST_RUN;
                end
            end
            default: begin
                next_state = WDT_ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state <= WDT_ST_RUN;
        end else begin
            state <= next_state;
        end
    end

    // counter advances on slow ticks only
    always_ff @(posedge clk) begin
        if (!resetn) begin
            wdt_count <= '0;
        end else if (state != WDT_ST_RUN) begin
            wdt_count <= '0;
        end else if (osc_tick) begin
            if (restart_pend || overflow) begin
                wdt_count <= '0;
            end else begin
                wdt_count <= wdt_count + `WDT_CNT_W'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            fire_cnt <= '0;
        end else if (state == WDT_ST_FIRE) begin
            fire_cnt <= fire_cnt + `WDT_FIRE_W'h1;
        end else begin
            fire_cnt <= '0;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            sys_reset_req <= 1'b0;
        end else begin
            sys_reset_req <= (next_state == WDT_ST_FIRE);
        end
    end

    // enable status registered alongside the state register
    always_ff @(posedge clk) begin
        if (!resetn) begin
            wdt_enabled <= 1'b1;
        end else begin
            wdt_enabled <= (next_state != WDT_ST_OFF);
        end
    end
endmodule : wdt_watchdog_unit

// *** wdt_map.svh ***
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH

// system clock and slow oscillator rates
`define WDT_CLK_FREQ_KHZ 200000
`define WDT_CLK_PERIOD_PS 5000
`define WDT_OSC_FREQ_KHZ 80
`define WDT_OSC_DIV (`WDT_CLK_FREQ_KHZ / `WDT_OSC_FREQ_KHZ)
`define WDT_OSC_DIV_W 12

// interval select: timeout = 2^(2*sel+4) slow ticks
`define WDT_SEL_W 3
`define WDT_SEL_RESET 3'h7
`define WDT_SEL_SHIFT_BASE 5'h04
`define WDT_CNT_W 20

// width of the system reset request, least time
`define WDT_FIRE_NS 100
`define WDT_FIRE_CYCLES ((`WDT_FIRE_NS * 1000 + `WDT_CLK_PERIOD_PS - 1) / `WDT_CLK_PERIOD_PS)
`define WDT_FIRE_W 8

`endif

// *** wdt_pkg.sv ***
package wdt_pkg;
    typedef enum logic [1:0] {
        WDT_ST_OFF = 2'h0,
        WDT_ST_RUN = 2'h1,
        WDT_ST_FIRE = 2'h3
    } wdt_state_e;
endpackage : wdt_pkg

// *** wdt_slow_osc_div.sv ***
`timescale 1ns/1ps
`include "wdt_map.svh"

module wdt_slow_osc_div (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // one-cycle pulse at the slow oscillator rate
    output logic osc_tick
);
    logic [`WDT_OSC_DIV_W-1:0] div_cnt;
    localparam logic [`WDT_OSC_DIV_W-1:0] DIV_LAST = `WDT_OSC_DIV_W'(`WDT_OSC_DIV - 1);

    always_ff @(posedge clk) begin
        if (!resetn) begin
            div_cnt <= '0;
            osc_tick <= 1'b0;
        end else if (div_cnt == DIV_LAST) begin
            div_cnt <= '0;
            osc_tick <= 1'b1;
        end else begin
            div_cnt <= div_cnt + `WDT_OSC_DIV_W'h1;
            osc_tick <= 1'b0;
        end
    end
endmodule : wdt_slow_osc_div

// *** wdt_watchdog_unit_sva.sv ***
`timescale 1ns/1ps
module wdt_watchdog_unit_sva (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // control
    input wire logic enable_we,
    input wire logic enable_val,
    input wire logic lock_req,
    input wire logic interval_we,
    input wire logic [2:0] interval_val,
    // status and reset outputs
    input wire logic wdt_enabled,
    input wire logic wdt_locked,
    input wire logic [2:0] wdt_interval,
    input wire logic [19:0] wdt_count,
    input wire logic write_refused,
    input wire logic osc_tick,
    input wire logic sys_reset_req,
    input wire logic rst_pin_out,
    input wire logic rst_pin_oe_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    property p_fire; $rose(sys_reset_req) |-> $past(osc_tick) ##19 sys_reset_req ##1 !sys_reset_req; endproperty
    a_fire: assert property (p_fire) else $error("bad fire");
    property p_pin; rst_pin_oe_n && !rst_pin_out; endproperty
    a_pin: assert property (p_pin) else $error("pin driven");
    property p_rst; $rose(resetn) |-> wdt_enabled && !wdt_locked && wdt_interval == 3'h7; endproperty
    a_rst: assert property (p_rst) else $error("bad reset");
    property p_lock; wdt_locked |=> wdt_locked && wdt_enabled; endproperty
    a_lock: assert property (p_lock) else $error("lock lost");
    property p_cfg; wdt_locked && interval_we |=> write_refused && $stable(wdt_interval); endproperty
    a_cfg: assert property (p_cfg) else $error("cfg taken");
    property p_dis; enable_we && !enable_val && !wdt_locked && !lock_req |=> !wdt_enabled; endproperty
    a_dis: assert property (p_dis) else $error("no disable");
    property p_tick; $changed(wdt_count) && wdt_count != 20'h0 |-> $past(osc_tick); endproperty
    a_tick: assert property (p_tick) else $error("fast count");
    property p_sel; interval_we && !wdt_locked && !lock_req |=> wdt_interval == $past(interval_val); endproperty
    a_sel: assert property (p_sel) else $error("bad sel");
    c_fire: cover property ($rose(sys_reset_req));
    c_refuse: cover property (write_refused);
    c_dis: cover property ($fell(wdt_enabled));
endmodule : wdt_watchdog_unit_sva

bind wdt_watchdog_unit wdt_watchdog_unit_sva u_sva (
    .clk(clk),
    .resetn(resetn),
    .enable_we(enable_we),
    .enable_val(enable_val),
    .lock_req(lock_req),
    .interval_we(interval_we),
    .interval_val(interval_val),
    .wdt_enabled(wdt_enabled),
    .wdt_locked(wdt_locked),
    .wdt_interval(wdt_interval),
    .wdt_count(wdt_count),
    .write_refused(write_refused),
    .osc_tick(osc_tick),
    .sys_reset_req(sys_reset_req),
    .rst_pin_out(rst_pin_out),
    .rst_pin_oe_n(rst_pin_oe_n)
);

// *** wdt_watchdog_unit_bench.sv ***
`timescale 1ns/1ps
`include "wdt_map.svh"
module wdt_watchdog_unit_bench import wdt_pkg::*;;
    logic clk = 0, resetn = 0, restart = 0, enable_we = 0, enable_val = 0;
    logic lock_req = 0, interval_we = 0, wdt_enabled, wdt_locked, write_refused, osc_tick;
    logic sys_reset_req, rst_pin_out, rst_pin_oe_n;
    logic [2:0] interval_val = 3'h0, wdt_interval;
    logic [19:0] wdt_count;
    int miscompares = 0, total_checks = 0;
    always #2.5 clk = ~clk;
    wdt_watchdog_unit dut (
        .clk(clk),
        .resetn(resetn),
        .restart(restart),
        .enable_we(enable_we),
        .enable_val(enable_val),
        .lock_req(lock_req),
        .interval_we(interval_we),
        .interval_val(interval_val),
        .wdt_enabled(wdt_enabled),
        .wdt_locked(wdt_locked),
        .wdt_interval(wdt_interval),
        .wdt_count(wdt_count),
        .write_refused(write_refused),
        .osc_tick(osc_tick),
        .sys_reset_req(sys_reset_req),
        .rst_pin_out(rst_pin_out),
        .rst_pin_oe_n(rst_pin_oe_n)
    );
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic drive(input logic [4:0] s, input logic [2:0] v);
        @(posedge clk);
        #1;
        {restart, enable_we, enable_val, lock_req, interval_we} = s;
        interval_val = v;
        @(posedge clk);
        #1;
        {restart, enable_we, enable_val, lock_req, interval_we} = 5'h00;
    endtask : drive
    task automatic wait_on(input int lim, input logic on_tick, input logic lvl, output int n);
        n = 0;
        while (n < lim && (on_tick ? osc_tick : sys_reset_req) !== lvl) begin
            @(posedge clk);
            #1;
            n++;
        end
        check(n < lim, 1'h1);
    endtask : wait_on
    task automatic do_reset;
        resetn = 0;
        repeat (5) @(posedge clk);
        #1;
        resetn = 1;
    endtask : do_reset
    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : summarize
    task automatic t_basic;
        int n;
        check({wdt_enabled, wdt_locked, wdt_interval}, 5'h17);
        check({rst_pin_oe_n, rst_pin_out}, 2'h2);
        drive(5'h08, 3'h0);
        check({wdt_enabled, wdt_count}, 21'h0);
        drive(5'h0c, 3'h0);
        wait_on(3000, 1'b1, 1'b1, n);
        drive(5'h00, 3'h0);
        wait_on(3000, 1'b1, 1'b1, n);
        check(n, `WDT_OSC_DIV - 2);
        drive(5'h00, 3'h0);
        check(wdt_count, 20'h2);
        drive(5'h10, 3'h0);
        wait_on(3000, 1'b1, 1'b1, n);
        drive(5'h00, 3'h0);
        check({sys_reset_req, wdt_count}, 21'h0);
        $display("basic done");
    endtask : t_basic
    task automatic t_lock;
        drive(5'h02, 3'h0);
        drive(5'h08, 3'h0);
        check({wdt_locked, wdt_enabled, write_refused}, 3'h7);
        drive(5'h01, 3'h3);
        check({write_refused, wdt_interval}, 4'hf);
        do_reset;
        check(wdt_locked, 1'h0);
        $display("lock done");
    endtask : t_lock
    task automatic t_overflow;
        int n;
        int lo;
        lo = (1 << `WDT_SEL_SHIFT_BASE) * `WDT_OSC_DIV + 1;
        drive(5'h01, 3'h0);
        check(wdt_interval, 3'h0);
        wait_on(50000, 1'b0, 1'b1, n);
        check(n >= lo && n < lo + `WDT_OSC_DIV, 1'h1);
        wait_on(100, 1'b0, 1'b0, n);
        check(n, `WDT_FIRE_CYCLES);
        check({wdt_enabled, wdt_count}, 21'h100000);
        check({rst_pin_oe_n, rst_pin_out}, 2'h2);
        $display("overflow done");
    endtask : t_overflow
    initial begin
        do_reset;
        t_basic;
        t_lock;
        t_overflow;
        summarize;
    end
    initial begin
        // about 60k cycles; the tests need about 50k
        #300000;
        miscompares++;
        summarize;
    end
endmodule : wdt_watchdog_unit_bench
